// ### core/parallel_byte_fifo_port.sv
// Parallel byte FIFO port: an external host moves bytes in and out of the
// device with active-low strobes and two active-low flow flags.
// Assumes strobes come from another domain; internal streams are on clk_sys.
`timescale 1ns/1ns
module parallel_byte_fifo_port
  import pfifo_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter bit SMALL_PACKAGE = 1'b0
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sync_mode,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic out_enable_n,
  input wire logic [DATA_W-1:0] bus_in,
  output logic [DATA_W-1:0] bus_out,
  output logic bus_oe_n,
  output logic rx_avail_n,
  output logic tx_space_n,
  output logic port_clk,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [DATA_W-1:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [DATA_W-1:0] tx_data
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    strobe_s s1;
    strobe_s s2;
    strobe_s prev;
    logic [DATA_W-1:0] d1;
    logic [DATA_W-1:0] d2;
    port_state_e st;
    logic sync_en;
    logic [DATA_W-1:0] bus_out;
    logic bus_oe_n;
    logic rx_avail_n;
    logic tx_space_n;
    logic [HOLD_W-1:0] rx_hold;
    logic [HOLD_W-1:0] tx_hold;
    logic [SCLK_W-1:0] sdiv;
    logic port_clk;
    logic cap_valid;
    logic [DATA_W-1:0] cap_data;
    byte_s head;
  } port_s;

  port_s q;
  port_s next_q;

  logic rxb_valid;
  logic rxb_ready;
  logic [DATA_W-1:0] rxb_data;
  logic txb_ready;
  logic [$clog2(DEPTH):0] rxb_level;
  logic [$clog2(DEPTH):0] txb_level;

  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic rd_low;
  logic oe_low;

  assign rd_fall = q.prev.rd_n && !q.s2.rd_n;
  assign rd_rise = !q.prev.rd_n && q.s2.rd_n;
  assign wr_fall = q.prev.wr_n && !q.s2.wr_n;
  assign rd_low = !q.s2.rd_n;
  assign oe_low = !q.s2.oe_n;

  // ------------------------------------------------------------------
  // Buffers
  // ------------------------------------------------------------------
  // Receive path: system stream into the buffer, head byte kept in q.head.
  pfifo_buf #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_rx_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_data),
    .out_valid(rxb_valid),
    .out_ready(rxb_ready),
    .out_data(rxb_data),
    .level(rxb_level)
  );

  // Transmit path: captured bus bytes out to the system stream.
  pfifo_buf #(
    .WIDTH(DATA_W),
    .DEPTH(DEPTH)
  ) u_tx_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(q.cap_valid),
    .in_ready(txb_ready),
    .in_data(q.cap_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data),
    .level(txb_level)
  );

  // The head register refills from the buffer whenever it is empty.
  assign rxb_ready = !q.head.valid;

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    next_q = q;
    // Two flip-flops on every strobe and data pin before any logic reads it.
    next_q.s1 = '{rd_n: rd_strobe_n, wr_n: wr_strobe_n, oe_n: out_enable_n};
    next_q.s2 = q.s1;
    next_q.prev = q.s2;
    next_q.d1 = bus_in;
    next_q.d2 = q.d1;
    next_q.cap_valid = 1'b0;
    next_q.sync_en = sync_mode && !SMALL_PACKAGE;

    if (q.rx_hold != '0)
    begin
      next_q.rx_hold = q.rx_hold - 1'b1;
    end
    if (q.tx_hold != '0)
    begin
      next_q.tx_hold = q.tx_hold - 1'b1;
    end

    if (rxb_valid && rxb_ready)
    begin
      next_q.head = '{data: rxb_data, valid: 1'b1};
    end

    case (q.st)
      ST_INIT:
      begin
        next_q.rx_avail_n = FLAG_BLOCK;
        next_q.tx_space_n = FLAG_BLOCK;
        next_q.st = ST_RUN;
      end
      ST_RUN:
      begin
        if (rd_fall && q.head.valid)
        begin
          next_q.bus_out = q.head.data;
          next_q.head.valid = 1'b0;
        end
        if (rd_rise)
        begin
          next_q.rx_avail_n = FLAG_BLOCK;
          next_q.rx_hold = HOLD_W'(FLAG_HOLD_CYC);
        end
        else if (q.rx_avail_n && q.rx_hold == '0 && q.head.valid && !rd_low)
        begin
          next_q.rx_avail_n = FLAG_GO;
        end

        if (wr_fall && txb_ready)
        begin
          next_q.cap_valid = 1'b1;
          next_q.cap_data = q.d2;
        end
        if (wr_fall)
        begin
          next_q.tx_space_n = FLAG_BLOCK;
          next_q.tx_hold = HOLD_W'(FLAG_HOLD_CYC);
        end
        // lower only with room, counting the byte in flight
        else if (q.tx_space_n && q.tx_hold == '0 && q.s2.wr_n && !q.cap_valid)
        begin
          if (txb_ready)
          begin
            next_q.tx_space_n = FLAG_GO;
          end
        end
        else if (!txb_ready)
        begin
          next_q.tx_space_n = FLAG_BLOCK;
        end
      end
      default:
      begin
        next_q.st = ST_INIT;
      end
    endcase

    if (q.sync_en)
    begin
      next_q.bus_oe_n = !(rd_low && oe_low);
    end
    else
    begin
      next_q.bus_oe_n = !rd_low;
    end

    // clock out from divider in synchronous variant only
    if (q.sync_en)
    begin
      if (q.sdiv == SCLK_W'(SCLK_HALF_CYC - 1))
      begin
        next_q.sdiv = '0;
        next_q.port_clk = !q.port_clk;
      end
      else
      begin
        next_q.sdiv = q.sdiv + 1'b1;
      end
    end
    else
    begin
      next_q.sdiv = '0;
      next_q.port_clk = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
      q.s1 <= '1;
      q.s2 <= '1;
      q.prev <= '1;
      q.st <= ST_INIT;
      q.bus_out <= DATA_RST;
      q.bus_oe_n <= 1'b1;
      q.rx_avail_n <= FLAG_BLOCK;
      q.tx_space_n <= FLAG_BLOCK;
    end
    else
    begin
      q <= next_q;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // single shared eight-bit bus
  assign bus_out = q.bus_out;
  assign bus_oe_n = q.bus_oe_n;
  assign rx_avail_n = q.rx_avail_n;
  assign tx_space_n = q.tx_space_n;
  assign port_clk = q.port_clk;

endmodule : parallel_byte_fifo_port

// ### core/pfifo_buf.sv
// Parameterised synchronous FIFO with valid/ready on both sides.
// Read data is the registered memory output; a look-ahead stage keeps
// the head word visible as soon as it is valid.
`timescale 1ns/1ns
module pfifo_buf
  import pfifo_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic head_ok;
  } buf_s;

  buf_s q;
  buf_s next_q;
  logic push;
  logic pop;
  logic fetch;
  logic [AW:0] count;
  logic [AW:0] used;
  logic [AW:0] head_ptr;
  logic [AW-1:0] rd_addr;

  assign count = q.wptr - q.rptr;
  // The word on show keeps its memory slot, so it counts as used; otherwise a
  // write into a nearly full buffer would overwrite the head before it is popped.
  assign used = count + (AW+1)'(q.head_ok);
  assign in_ready = (used < (AW+1)'(DEPTH));
  assign push = in_valid && in_ready;
  assign out_valid = q.head_ok;
  assign pop = q.head_ok && out_ready;
  // The read port is addressed by rptr; a new head is valid one cycle later.
  assign fetch = (q.wptr != q.rptr) && (!q.head_ok || pop);
  // The head word sits one slot behind rptr; the read port re-reads it until it is popped.
  assign head_ptr = q.rptr - 1'b1;
  assign rd_addr = fetch ? q.rptr[AW-1:0] : head_ptr[AW-1:0];
  assign level = used;

  always_comb
  begin
    next_q = q;
    if (push)
    begin
      next_q.wptr = q.wptr + 1'b1;
    end
    if (pop)
    begin
      next_q.head_ok = 1'b0;
    end
    if (fetch)
    begin
      next_q.rptr = q.rptr + 1'b1;
      next_q.head_ok = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  pfifo_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_mem (
    .clk_sys(clk_sys),
    .wr_en(push),
    .wr_addr(q.wptr[AW-1:0]),
    .wr_data(in_data),
    .rd_addr(rd_addr),
    .rd_data(out_data)
  );

endmodule : pfifo_buf

// ### core/pfifo_mem.sv
// Small register-array memory with registered read data.
// Assumes a single clock; writes and reads may share a cycle.
`timescale 1ns/1ns
module pfifo_mem
  import pfifo_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
)
(
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule : pfifo_mem

// ### core/pfifo_pkg.sv
// Shared constants and carriers for the parallel byte port.
// Assumes a single 250 MHz system clock and synchronous active-high reset.
package pfifo_pkg;

  // ------------------------------------------------------------------
  // Widths and depths
  // ------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  // Least time a flag stays inactive after a strobe cycle.
  localparam int FLAG_HOLD_NS = 100;
  localparam int FLAG_HOLD_CYC = (FLAG_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HOLD_W = 8;
  // Synchronous mode clock divider: half period in system cycles.
  localparam int SCLK_HALF_CYC = 3;
  localparam int SCLK_W = 4;

  // ------------------------------------------------------------------
  // Flag levels and reset values
  // ------------------------------------------------------------------
  localparam logic FLAG_BLOCK = 1'b1;
  localparam logic FLAG_GO = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic oe_n;
  } strobe_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic valid;
  } byte_s;

  typedef enum logic [1:0] {
    ST_INIT,
    ST_RUN
  } port_state_e;

endpackage : pfifo_pkg

// ### testbench/pfifo_host.sv
// Behavioural host that paces the port with strobes and resolves the shared bus.
// Assumes tasks are entered one clock-plus-1ns after a rising edge.
`timescale 1ns/1ns
module pfifo_host
  import pfifo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [DATA_W-1:0] bus_out,
  input wire logic bus_oe_n,
  input wire logic rx_avail_n,
  input wire logic tx_space_n,
  output logic rd_strobe_n,
  output logic wr_strobe_n,
  output logic out_enable_n,
  output logic [DATA_W-1:0] bus_in
);
  logic drive = 1'b0;
  logic [DATA_W-1:0] wdata = 8'h00;
  logic [DATA_W-1:0] idle = 8'h5a;
  initial
  begin
    rd_strobe_n = 1'b1;
    wr_strobe_n = 1'b1;
    out_enable_n = 1'b1;
  end
  // An undriven bus shows a changing pattern, never the last byte.
  always @(posedge clk_sys) idle <= ~idle + 8'h01;
  assign bus_in = !bus_oe_n ? bus_out : (drive ? wdata : idle);
  task automatic wait_low(input bit tx, output bit ok);
    int k;
    k = 0;
    while ((tx ? tx_space_n : rx_avail_n) !== 1'b0 && k < 300)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    ok = (k < 300);
  endtask : wait_low
  task automatic read_byte(output logic [DATA_W-1:0] d, output bit ok);
    wait_low(1'b0, ok);
    if (ok)
    begin
      rd_strobe_n = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      d = bus_in;
      rd_strobe_n = 1'b1;
      repeat (6) @(posedge clk_sys);
      #1;
    end
  endtask : read_byte
  task automatic write_byte(input logic [DATA_W-1:0] d, output bit ok);
    wait_low(1'b1, ok);
    if (ok)
    begin
      wdata = d;
      drive = 1'b1;
      @(posedge clk_sys);
      #1;
      wr_strobe_n = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      wr_strobe_n = 1'b1;
      repeat (3) @(posedge clk_sys);
      #1;
      drive = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
    end
  endtask : write_byte
endmodule : pfifo_host

// ### testbench/pfifo_port_props.sv
// Concurrent checks on the parallel byte port pins.
// Assumes one clock, clk_sys, and a synchronous active-high rst.
`timescale 1ns/1ns
module pfifo_port_props
  import pfifo_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sync_mode,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic bus_oe_n,
  input wire logic rx_avail_n,
  input wire logic tx_space_n,
  input wire logic port_clk
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [4:0] rx_hi;
  logic [4:0] tx_hi;
  // Counters saturate so that the flags' first fall after reset is not judged as a short hold.
  always_ff @(posedge clk_sys)
  begin
    rx_hi <= (rst || (rx_avail_n && rx_hi == 5'h1f)) ? 5'h1f : (rx_avail_n ? rx_hi + 5'h01 : 5'h00);
    tx_hi <= (rst || (tx_space_n && tx_hi == 5'h1f)) ? 5'h1f : (tx_space_n ? tx_hi + 5'h01 : 5'h00);
  end
  property p_oe_idle; rd_strobe_n [*6] |-> bus_oe_n; endproperty
  property p_oe_drive; (!rd_strobe_n && !sync_mode) [*6] |-> !bus_oe_n; endproperty
  property p_rx_rise; $rose(rd_strobe_n) |-> ##[1:5] rx_avail_n; endproperty
  property p_tx_fall; $fell(wr_strobe_n) |-> ##[1:5] tx_space_n; endproperty
  property p_rx_keep; (rd_strobe_n [*6] ##0 !rx_avail_n) |=> !rx_avail_n; endproperty
  property p_rx_hold; $fell(rx_avail_n) |-> rx_hi >= 5'h14; endproperty
  property p_tx_hold; $fell(tx_space_n) |-> tx_hi >= 5'h14; endproperty
  property p_reset; $fell(rst) |-> (rx_avail_n && tx_space_n) [*2]; endproperty
  property p_clk_idle; !sync_mode [*4] |-> !port_clk; endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("bus driven while read strobe high");
  a_oe_drive: assert property (p_oe_drive)
    else $error("bus not driven while read strobe low");
  a_rx_rise: assert property (p_rx_rise)
    else $error("receive flag not raised after read");
  a_tx_fall: assert property (p_tx_fall)
    else $error("transmit flag not raised after write");
  a_rx_keep: assert property (p_rx_keep)
    else $error("receive flag dropped without a read");
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive flag inactive time too short");
  a_tx_hold: assert property (p_tx_hold)
    else $error("transmit flag inactive time too short");
  a_reset: assert property (p_reset)
    else $error("flags low right after reset");
  a_clk_idle: assert property (p_clk_idle)
    else $error("port clock runs in asynchronous mode");
  c_read: cover property ($rose(rd_strobe_n) ##[1:5] rx_avail_n);
  c_write: cover property ($fell(wr_strobe_n) ##[1:5] tx_space_n);
  c_clk: cover property ($rose(port_clk));
endmodule : pfifo_port_props

bind parallel_byte_fifo_port pfifo_port_props u_props (.clk_sys(clk_sys), .rst(rst),
  .sync_mode(sync_mode), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
  .bus_oe_n(bus_oe_n), .rx_avail_n(rx_avail_n), .tx_space_n(tx_space_n), .port_clk(port_clk));

// ### testbench/test_parallel_byte_fifo_port.sv
// Self-checking bench: random bytes through both buffers, full and empty cases.
// Assumes the host model and the bound checker beside the port.
`timescale 1ns/1ns
module test_parallel_byte_fifo_port
  import pfifo_pkg::*;
;
  logic clk_sys, rst, sync_mode, rd_strobe_n, wr_strobe_n, out_enable_n, bus_oe_n;
  logic rx_avail_n, tx_space_n, port_clk, rx_valid, rx_ready, tx_valid, tx_ready, tx_en;
  logic [DATA_W-1:0] bus_in, bus_out, rx_data, tx_data, d, e;
  logic [31:0] seed = 32'h4bee_2851;
  logic [31:0] r;
  logic [DATA_W-1:0] rxq[$], txq[$];
  int fail_count = 0, samples_checked = 0, n, m, t;
  bit ok;
  parallel_byte_fifo_port #(.DEPTH(FIFO_DEPTH), .SMALL_PACKAGE(1'b0)) DUT (.clk_sys(clk_sys),
    .rst(rst), .sync_mode(sync_mode), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n),
    .out_enable_n(out_enable_n), .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
    .rx_avail_n(rx_avail_n), .tx_space_n(tx_space_n), .port_clk(port_clk),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data));
  pfifo_host host (.clk_sys(clk_sys), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
    .rx_avail_n(rx_avail_n), .tx_space_n(tx_space_n), .rd_strobe_n(rd_strobe_n),
    .wr_strobe_n(wr_strobe_n), .out_enable_n(out_enable_n), .bus_in(bus_in));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic chk(input bit good, input string msg);
    samples_checked++;
    if (!good)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Offers up to n random bytes to the receive stream; stops when refused.
  task automatic push(input int n, output int m);
    int k;
    m = 0;
    for (int i = 0; i < n && k < 40; i++)
    begin
      r = rnd();
      rx_data = r[7:0];
      rx_valid = 1'b1;
      k = 0;
      while (rx_ready !== 1'b1 && k < 40)
      begin
        @(posedge clk_sys);
        #1;
        k++;
      end
      if (k < 40)
      begin
        @(posedge clk_sys);
        #1;
        rxq.push_back(rx_data);
        m++;
      end
    end
    rx_valid = 1'b0;
  endtask : push
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1)
    begin
      chk(txq.size() > 0 && tx_data === txq[0], "transmit byte mismatch");
      if (txq.size() > 0) void'(txq.pop_front());
    end
    #1;
    r = rnd();
    tx_ready = tx_en & r[0];
  end
  initial
  begin
    #100000;
    fail_count++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    sync_mode = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_en = 1'b0;
    tx_ready = 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    @(posedge clk_sys);
    #1;
    chk(rx_avail_n === 1'b1 && tx_space_n === 1'b1 && bus_oe_n === 1'b1, "reset state");
    n = 0;
    ok = 1'b1;
    for (int i = 0; i < 32; i++)
    begin
      if (i == 24) tx_en = 1'b1;
      r = rnd();
      txq.push_back(r[7:0]);
      host.write_byte(r[7:0], ok);
      if (ok) n++;
      else void'(txq.pop_back());
    end
    chk(n == FIFO_DEPTH + 8, "transmit buffer capacity");
    repeat (200) @(posedge clk_sys);
    #1;
    chk(txq.size() == 0 && tx_space_n === 1'b0, "transmit drain");
    push(24, m);
    chk(m >= FIFO_DEPTH && m < 24, "receive buffer capacity");
    repeat (m)
    begin
      host.read_byte(d, ok);
      e = rxq.pop_front();
      chk(ok && d === e, "receive byte mismatch");
    end
    host.read_byte(d, ok);
    chk(!ok, "read allowed on empty buffer");
    sync_mode = 1'b1;
    t = 0;
    repeat (60)
    begin
      @(posedge clk_sys);
      #1;
      if (port_clk === 1'b1) t++;
    end
    chk(t >= 25 && t <= 32, "port clock duty");
    // In the synchronous variant the read strobe alone must not drive the bus.
    host.rd_strobe_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk(bus_oe_n === 1'b1, "bus driven without output enable");
    host.out_enable_n = 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk(bus_oe_n === 1'b0, "bus not driven with output enable");
    host.rd_strobe_n = 1'b1;
    host.out_enable_n = 1'b1;
    repeat (6) @(posedge clk_sys);
    #1;
    chk(bus_oe_n === 1'b1, "bus still driven after read");
    sync_mode = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    chk(port_clk === 1'b0, "port clock stopped");
    tally_and_finish();
  end
endmodule : test_parallel_byte_fifo_port
